// file: bench/lcbm_far_model.sv
`timescale 1ns/1ps
module lcbm_far_model (
  input wire logic sys_clk,
  input wire logic pair_on,
  input wire logic [7:0] gap,
  input wire logic push,
  output logic [3:0] mute_sensor,
  output logic override_in
);
  logic [7:0] cnt_q;
  // A slow object reaches the second sensor gap cycles after the first.
  always_ff @(posedge sys_clk) begin
    if (!pair_on) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign mute_sensor = {2'h0, pair_on && (cnt_q >= gap), pair_on};
  assign override_in = push;
endmodule // lcbm_far_model

// file: bench/light_curtain_blanking_muting_tb.sv
`timescale 1ns/1ps
module light_curtain_blanking_muting_tb;
  import lcbm_pkg::*;
  logic sys_clk, rstn, cascade_present, pair_on, push, status_hi, override_in;
  logic mute_enable_in, bready, rready;
  logic [31:0] beam_blocked, wdata, rdata, d;
  logic [7:0] gap, awaddr, araddr;
  logic [3:0] mute_sensor;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r, br;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  // Zone type, beams inside the zone, and whether HI is expected.
  localparam logic [15:0] CASES [9] = '{16'h3001, 16'h3031, 16'h3070, 16'h3110, 16'h3061,
    16'h4111, 16'h4380, 16'h2000, 16'h2061};

  lcbm_top #(.NUM_BEAMS(32), .TICK_DIV(10)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .beam_blocked(beam_blocked), .mute_sensor(mute_sensor),
    .mute_enable_in(mute_enable_in), .override_in(override_in),
    .cascade_present(cascade_present),
    .status_hi(status_hi), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  lcbm_far_model i_far (.sys_clk(sys_clk), .pair_on(pair_on), .gap(gap), .push(push),
    .mute_sensor(mute_sensor), .override_in(override_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Each request channel drops at the edge that takes it; bready and rready rise only once
  // the request is in, so back-to-back calls never drive one signal twice in a time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge sys_clk); while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!rvalid);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    rstn = 1'b0;
    beam_blocked = 32'h0;
    cascade_present = 1'b0;
    pair_on = 1'b0;
    push = 1'b0;
    gap = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    mute_enable_in = 1'b0;
    bready = 1'b0;
    rready = 1'b0;
    br = 2'b00;
    wt(5);
    chk({31'h0, status_hi}, 32'h0);
    rstn <= 1'b1;
    rd(CTRL_OFS, d, r);
    chk(d, CTRL_RST);
    rd(MUTE_MAX_OFS, d, r);
    chk(d, MUTE_MAX_RST);
    rd(DELAY_OFS, d, r);
    chk(d, DELAY_RST);
    rd(8'h60, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(STATUS_OFS, 32'h0000_00FF);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    beam_blocked <= 32'h0000_000C;
    wt(5);
    chk({31'h0, status_hi}, 32'h0);
    rd(BEAMS_OFS, d, r);
    chk(d, 32'h0000_000C);
    wr(ZONE0_OFS, 32'h0004_0301);
    wr(CTRL_OFS, 32'h1);
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    wt(5);
    chk({31'h0, status_hi}, 32'h1);
    for (int i = 0; i < 9; i++) begin
      wr(ZONE0_OFS + 8'h04, {8'h02, 8'h0F, 8'h0A, 5'h00, CASES[i][14:12]});
      beam_blocked <= {17'h0, CASES[i][9:4], 9'h00C};
      wt(5);
      chk({31'h0, status_hi}, {31'h0, CASES[i][0]});
    end
    $display("test blanking done");
    beam_blocked <= 32'h0;
    wr(CTRL_OFS, 32'h6);
    wr(SENS_WIN_OFS, 32'h1);
    wr(MUTE_MAX_OFS, 32'h1);
    pair_on <= 1'b1;
    wt(150);
    rd(STATUS_OFS, d, r);
    chk({31'h0, d[2]}, 32'h0);
    pair_on <= 1'b0;
    cascade_present <= 1'b1;
    gap <= 8'd100;
    wt(20);
    pair_on <= 1'b1;
    wt(200);
    rd(STATUS_OFS, d, r);
    chk({30'h0, d[7], d[2]}, 32'h2);
    pair_on <= 1'b0;
    gap <= 8'h00;
    wt(20);
    pair_on <= 1'b1;
    wt(60);
    rd(STATUS_OFS, d, r);
    chk({31'h0, d[2]}, 32'h0);
    wt(45);
    rd(STATUS_OFS, d, r);
    chk({31'h0, d[2]}, 32'h1);
    beam_blocked <= 32'h0010_0000;
    wt(5);
    chk({31'h0, status_hi}, 32'h1);
    wt(1100);
    chk({31'h0, status_hi}, 32'h0);
    wr(CTRL_OFS, 32'h26);
    wr(OVR_TIME_OFS, 32'h1);
    push <= 1'b1;
    wt(1);
    push <= 1'b0;
    wt(10);
    chk({31'h0, status_hi}, 32'h1);
    wt(5100);
    chk({31'h0, status_hi}, 32'h0);
    pair_on <= 1'b0;
    beam_blocked <= 32'h0;
    wr(CTRL_OFS, 32'h4E);
    wr(PART_OFS, 32'h0000_1C05);
    wt(20);
    rd(STATUS_OFS, d, r);
    chk({30'h0, d[3], d[2]}, 32'h0);
    pair_on <= 1'b1;
    wt(100);
    rd(STATUS_OFS, d, r);
    chk({31'h0, d[2]}, 32'h0);
    mute_enable_in <= 1'b1;
    wt(100);
    rd(STATUS_OFS, d, r);
    chk({31'h0, d[2]}, 32'h1);
    beam_blocked <= 32'h0000_0100;
    wt(5);
    chk({31'h0, status_hi}, 32'h1);
    beam_blocked <= 32'h0000_0101;
    wt(5);
    chk({31'h0, status_hi}, 32'h0);
    $display("test muting done");
    finish_test();
  end
endmodule // light_curtain_blanking_muting_tb

// file: rtl/lcbm_pkg.sv
package lcbm_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MUTE_MAX_OFS = 8'h04;
  localparam logic [7:0] SENS_WIN_OFS = 8'h08;
  localparam logic [7:0] CURT_TIME_OFS = 8'h0C;
  localparam logic [7:0] OVR_TIME_OFS = 8'h10;
  localparam logic [7:0] DELAY_OFS = 8'h14;
  localparam logic [7:0] PART_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] BEAMS_OFS = 8'h20;
  localparam logic [7:0] ZONE0_OFS = 8'h40;
  localparam int NUM_ZONES = 8;
  // Control register fields.
  localparam int CTRL_BLANK_BIT = 0;
  localparam int CTRL_MUTE_BIT = 1;
  localparam int CTRL_PAT_LSB = 2;
  localparam int CTRL_CURT_BIT = 4;
  localparam int CTRL_OVR_BIT = 5;
  localparam int CTRL_PART_BIT = 6;
  localparam int CTRL_OUT_LSB = 7;
  // Zone register fields.
  localparam int ZONE_TYPE_LSB = 0;
  localparam int ZONE_FROM_LSB = 8;
  localparam int ZONE_TO_LSB = 16;
  localparam int ZONE_SIZE_LSB = 24;
  localparam int ZONE_TOL_LSB = 28;
  // Reset values, in the units of each register.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MUTE_MAX_RST = 32'h0000_012C;
  localparam logic [31:0] SENS_WIN_RST = 32'h0000_0050;
  localparam logic [31:0] CURT_TIME_RST = 32'h0000_0050;
  localparam logic [31:0] OVR_TIME_RST = 32'h0000_0004;
  localparam logic [31:0] DELAY_RST = 32'h0000_0508;
  localparam logic [31:0] PART_RST = 32'h0000_0000;
  localparam logic [31:0] ZONE_RST = 32'h0000_0000;
  // Timing base: one tick every 10 ms at a 10 ns clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SENS_STEP_MS = 50;
  localparam int MUTE_STEP_MS = 1000;
  localparam int OVR_STEP_MS = 5000;
  localparam int DELAY_STEP_MS = 10;
  localparam logic [31:0] SENS_STEP_TICKS = 32'(SENS_STEP_MS / TICK_MS);
  localparam logic [31:0] MUTE_STEP_TICKS = 32'(MUTE_STEP_MS / TICK_MS);
  localparam logic [31:0] OVR_STEP_TICKS = 32'(OVR_STEP_MS / TICK_MS);
  localparam logic [31:0] DELAY_STEP_TICKS = 32'(DELAY_STEP_MS / TICK_MS);
  // Largest object an unmonitored floating zone tolerates.
  localparam logic [7:0] NOMON_MAX_RUN = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ZONE_OFF = 3'b000,
    ZONE_FIXED = 3'b001,
    ZONE_FLOAT_MON = 3'b010,
    ZONE_NOMON_ONE = 3'b011,
    ZONE_NOMON_MULTI = 3'b100
  } lcbm_zone_t;

  typedef enum logic [1:0] {
    PAT_FOUR_BIDIR = 2'b00,
    PAT_L_UNIDIR = 2'b01,
    PAT_T_BIDIR = 2'b10,
    PAT_T_ENABLE = 2'b11
  } lcbm_pat_t;

  typedef enum logic [2:0] {
    MST_IDLE = 3'b000,
    MST_WAIT = 3'b001,
    MST_DLY_ON = 3'b010,
    MST_MUTED = 3'b011,
    MST_DLY_OFF = 3'b100,
    MST_TERR = 3'b101,
    MST_MERR = 3'b110
  } lcbm_mst_t;
endpackage

// file: rtl/lcbm_top.sv
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module lcbm_top #(
  parameter int NUM_BEAMS = 32,
  parameter int TICK_DIV = lcbm_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [NUM_BEAMS-1:0] beam_blocked,
  input wire logic [3:0] mute_sensor,
  input wire logic mute_enable_in,
  input wire logic override_in,
  input wire logic cascade_present,
  output logic status_hi,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lcbm_pkg::*;

  localparam int PIN_W = NUM_BEAMS + 7;

  // Pins come from outside the clock domain: two flops before use.
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {cascade_present, override_in, mute_enable_in, mute_sensor, beam_blocked};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic [NUM_BEAMS-1:0] blk;
  logic [3:0] sens;
  logic mute_ena;
  logic ovr_pin;
  logic casc;
  assign {casc, ovr_pin, mute_ena, sens, blk} = pin_s2_q;

  // Tick divider.
  // common timer tick
  logic [31:0] div_q;
  logic tick;
  assign tick = (div_q == 32'(TICK_DIV - 1));
  always_ff @(posedge sys_clk) begin
    if (!rstn || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // Register file.
  logic [31:0] ctrl_q, mute_max_q, sens_win_q, curt_time_q, ovr_time_q, delay_q, part_q;
  logic [31:0] zone_q [NUM_ZONES];
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_got_q, w_got_q;
  logic wr_fire;
  logic wr_hit;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_hit = (aw_addr_q[7:2] <= STATUS_OFS[7:2] - 6'h1) ||
                  (aw_addr_q[7:2] >= ZONE0_OFS[7:2] &&
                   aw_addr_q[7:2] < ZONE0_OFS[7:2] + 6'(NUM_ZONES));

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
      mute_max_q <= MUTE_MAX_RST;
      sens_win_q <= SENS_WIN_RST;
      curt_time_q <= CURT_TIME_RST;
      ovr_time_q <= OVR_TIME_RST;
      delay_q <= DELAY_RST;
      part_q <= PART_RST;
    end else if (wr_fire) begin
      case (aw_addr_q)
        CTRL_OFS: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
        MUTE_MAX_OFS: mute_max_q <= merge(mute_max_q, w_data_q, w_strb_q);
        SENS_WIN_OFS: sens_win_q <= merge(sens_win_q, w_data_q, w_strb_q);
        CURT_TIME_OFS: curt_time_q <= merge(curt_time_q, w_data_q, w_strb_q);
        OVR_TIME_OFS: ovr_time_q <= merge(ovr_time_q, w_data_q, w_strb_q);
        DELAY_OFS: delay_q <= merge(delay_q, w_data_q, w_strb_q);
        PART_OFS: part_q <= merge(part_q, w_data_q, w_strb_q);
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Zone evaluation: one register, mask and verdict per zone.
  function automatic void scan(input logic [NUM_BEAMS-1:0] mask, input logic [NUM_BEAMS-1:0] b,
                               output logic [7:0] cnt, output logic [7:0] objs,
                               output logic [7:0] maxrun);
    logic [7:0] run;
    logic prev;
    cnt = '0;
    objs = '0;
    maxrun = '0;
    run = '0;
    prev = 1'b0;
    for (int i = 0; i < NUM_BEAMS; i++) begin
      if (mask[i] && b[i]) begin
        cnt = cnt + 8'h1;
        run = run + 8'h1;
        if (run > maxrun) begin
          maxrun = run;
        end
        // A run of adjacent blocked beams counts once.
        if (!prev) begin
          objs = objs + 8'h1;
        end
        prev = 1'b1;
      end else begin
        run = '0;
        prev = 1'b0;
      end
    end
  endfunction

  logic blank_on;
  logic [NUM_ZONES-1:0] zone_ok;
  logic [NUM_BEAMS-1:0] zone_mask [NUM_ZONES];
  logic [NUM_BEAMS-1:0] any_zone;
  assign blank_on = ctrl_q[CTRL_BLANK_BIT] && !ctrl_q[CTRL_PART_BIT];

  for (genvar z = 0; z < NUM_ZONES; z++) begin : g_zone
    lcbm_zone_t ztype;
    logic [7:0] zfrom, zto, zcnt, zobjs, zrun, zlen;
    logic [3:0] zsize;
    logic [1:0] ztol;
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        zone_q[z] <= ZONE_RST;
      end else if (wr_fire && aw_addr_q == ZONE0_OFS + 8'(4 * z)) begin
        zone_q[z] <= merge(zone_q[z], w_data_q, w_strb_q);
      end
    end
    assign ztype = lcbm_zone_t'(zone_q[z][ZONE_TYPE_LSB +: 3]);
    assign zfrom = zone_q[z][ZONE_FROM_LSB +: 8];
    assign zto = zone_q[z][ZONE_TO_LSB +: 8];
    assign zsize = zone_q[z][ZONE_SIZE_LSB +: 4];
    assign ztol = zone_q[z][ZONE_TOL_LSB +: 2];
    assign zlen = zto - zfrom + 8'h1;
    for (genvar i = 0; i < NUM_BEAMS; i++) begin : g_bit
      assign zone_mask[z][i] = blank_on && ztype != ZONE_OFF &&
                               8'(i + 1) >= zfrom && 8'(i + 1) <= zto;
    end
    always_comb begin
      scan(zone_mask[z], blk, zcnt, zobjs, zrun);
      case (blank_on ? ztype : ZONE_OFF)
        // fixed range may shrink by tolerance
        ZONE_FIXED: zone_ok[z] = (zcnt + {6'h0, ztol}) >= zlen;
        ZONE_FLOAT_MON: zone_ok[z] = zobjs == 8'h1 && zrun <= {4'h0, zsize} &&
                                     (zrun + {6'h0, ztol}) >= {4'h0, zsize};
        ZONE_NOMON_ONE: zone_ok[z] = zobjs <= 8'h1 && zrun <= NOMON_MAX_RUN;
        ZONE_NOMON_MULTI: zone_ok[z] = zrun <= NOMON_MAX_RUN;
        default: zone_ok[z] = 1'b1;
      endcase
    end
  end

  always_comb begin
    any_zone = '0;
    for (int z = 0; z < NUM_ZONES; z++) begin
      any_zone = any_zone | zone_mask[z];
    end
  end

  logic [7:0] ocnt, oobjs, orun, pcnt, pobjs, prun;
  logic outside_ok;
  logic [1:0] out_mode;
  logic [NUM_BEAMS-1:0] part_out;
  assign out_mode = ctrl_q[CTRL_OUT_LSB +: 2];
  for (genvar i = 0; i < NUM_BEAMS; i++) begin : g_part
    assign part_out[i] = 8'(i + 1) < part_q[7:0] || 8'(i + 1) > part_q[15:8];
  end
  always_comb begin
    scan(~any_zone, blk, ocnt, oobjs, orun);
    scan(part_out, blk, pcnt, pobjs, prun);
    outside_ok = (out_mode == 2'b00) ? (ocnt == 8'h0) : (oobjs <= {6'h0, out_mode});
  end

  // Muting supervision.
  lcbm_mst_t mst_q;
  lcbm_pat_t pat;
  logic mute_avail, trig, full, sens_clear, curtain_hit;
  logic [31:0] tmr_q, mtime_q, otime_q;
  logic curt_seen_q, ovr_prev_q, ovr_act_q;
  logic ovr_rise;
  assign pat = lcbm_pat_t'(ctrl_q[CTRL_PAT_LSB +: 2]);
  assign mute_avail = ctrl_q[CTRL_MUTE_BIT] && casc;
  assign sens_clear = (sens == 4'h0);
  assign curtain_hit = (blk != '0);
  always_comb begin
    case (pat)
      PAT_FOUR_BIDIR: begin
        trig = !sens_clear;
        full = (sens[0] && sens[1]) || (sens[2] && sens[3]);
      end
      PAT_T_ENABLE: begin
        trig = (sens[0] || sens[1]) && mute_ena;
        full = sens[0] && sens[1] && mute_ena;
      end
      default: begin
        trig = sens[0] || sens[1];
        full = sens[0] && sens[1];
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mst_q <= MST_IDLE;
      tmr_q <= '0;
    end else begin
      if (tick) begin
        tmr_q <= tmr_q + 32'h1;
      end
      case (mst_q)
        MST_IDLE: if (mute_avail && full) begin
          mst_q <= MST_DLY_ON;
          tmr_q <= '0;
        end else if (mute_avail && trig) begin
          mst_q <= MST_WAIT;
          tmr_q <= '0;
        end
        MST_WAIT: if (full) begin
          mst_q <= MST_DLY_ON;
          tmr_q <= '0;
        end else if (!trig) begin
          mst_q <= MST_IDLE;
        end else if (tmr_q >= sens_win_q * SENS_STEP_TICKS) begin
          mst_q <= MST_TERR;
        end
        MST_DLY_ON: if (!full) begin
          mst_q <= MST_IDLE;
        end else if (tmr_q >= {24'h0, delay_q[7:0]} * DELAY_STEP_TICKS) begin
          mst_q <= MST_MUTED;
          tmr_q <= '0;
        end
        MST_MUTED, MST_DLY_OFF: if (mtime_q >= mute_max_q * MUTE_STEP_TICKS) begin
          mst_q <= MST_MERR;
        end else if (ctrl_q[CTRL_CURT_BIT] && !curt_seen_q &&
                     mtime_q >= curt_time_q * SENS_STEP_TICKS) begin
          mst_q <= MST_MERR;
        end else if (mst_q == MST_MUTED && !full) begin
          mst_q <= MST_DLY_OFF;
          tmr_q <= '0;
        end else if (mst_q == MST_DLY_OFF && full) begin
          mst_q <= MST_MUTED;
        end else if (mst_q == MST_DLY_OFF &&
                     tmr_q >= {24'h0, delay_q[15:8]} * DELAY_STEP_TICKS) begin
          mst_q <= MST_IDLE;
        end
        MST_TERR: if (sens_clear) begin
          mst_q <= MST_IDLE;
        end
        MST_MERR: if (sens_clear && !curtain_hit && !ovr_act_q) begin
          mst_q <= MST_IDLE;
        end
        default: mst_q <= MST_IDLE;
      endcase
    end
  end

  // Time spent muted, and whether the curtain was broken in it.
  always_ff @(posedge sys_clk) begin
    if (!rstn || !(mst_q == MST_MUTED || mst_q == MST_DLY_OFF)) begin
      mtime_q <= '0;
      curt_seen_q <= 1'b0;
    end else begin
      if (tick) begin
        mtime_q <= mtime_q + 32'h1;
      end
      if (curtain_hit) begin
        curt_seen_q <= 1'b1;
      end
    end
  end

  assign ovr_rise = ovr_pin && !ovr_prev_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ovr_prev_q <= 1'b0;
      ovr_act_q <= 1'b0;
      otime_q <= '0;
    end else begin
      ovr_prev_q <= ovr_pin;
      if (ovr_rise && mst_q == MST_MERR && ctrl_q[CTRL_OVR_BIT] && ovr_time_q[7:0] != 8'h0) begin
        ovr_act_q <= 1'b1;
        otime_q <= '0;
      end else if (ovr_act_q) begin
        if (tick) begin
          otime_q <= otime_q + 32'h1;
        end
        if (otime_q >= {24'h0, ovr_time_q[7:0]} * OVR_STEP_TICKS || mst_q != MST_MERR) begin
          ovr_act_q <= 1'b0;
        end
      end
    end
  end

  logic muted, eval_ok;
  assign muted = (mst_q == MST_MUTED || mst_q == MST_DLY_OFF);
  assign eval_ok = muted ? (!ctrl_q[CTRL_PART_BIT] || pcnt == 8'h0) :
                   (&zone_ok && outside_ok);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_hi <= 1'b0;
    end else begin
      status_hi <= ovr_act_q || (mst_q != MST_MERR && eval_ok);
    end
  end

  // Read channel.
  logic [31:0] rd_val;
  logic rd_hit;
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS: rd_val = ctrl_q;
      MUTE_MAX_OFS: rd_val = mute_max_q;
      SENS_WIN_OFS: rd_val = sens_win_q;
      CURT_TIME_OFS: rd_val = curt_time_q;
      OVR_TIME_OFS: rd_val = ovr_time_q;
      DELAY_OFS: rd_val = delay_q;
      PART_OFS: rd_val = part_q;
      STATUS_OFS: rd_val = {24'h0, mst_q == MST_TERR, &zone_ok, outside_ok, ovr_act_q,
                            mst_q == MST_MERR, muted, casc, status_hi};
      BEAMS_OFS: rd_val = 32'(blk);
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
        for (int z = 0; z < NUM_ZONES; z++) begin
          if (s_axi_araddr == ZONE0_OFS + 8'(4 * z)) begin
            rd_val = zone_q[z];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  status_reset_a: assert property (@(posedge sys_clk) !rstn |=> !status_hi)
    else $error("status high after reset");
  // error state without override is LO
  merr_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mst_q == MST_MERR && !ovr_act_q) |=> !status_hi) else $error("status high in error");
  override_hi_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ovr_act_q |=> status_hi) else $error("override did not force high");
  ovr_edge_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(ovr_act_q) |-> $past(ovr_rise)) else $error("override started without edge");
  mute_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mst_q == MST_IDLE && !mute_avail) |=> mst_q == MST_IDLE) else $error("muting left idle");
  terr_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    mst_q == MST_TERR |=> (mst_q == MST_TERR || mst_q == MST_IDLE)) else $error("bad exit");
  mute_entry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mst_q == MST_MUTED && $past(mst_q) != MST_MUTED) |->
    ($past(mst_q) == MST_DLY_ON || $past(mst_q) == MST_DLY_OFF)) else $error("muted early");
  // blocked outside partial range is LO
  partial_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (muted && ctrl_q[CTRL_PART_BIT] && pcnt != 8'h0 && !ovr_act_q) |=> !status_hi)
    else $error("partial outside beam ignored");
  // two objects in single zone fail
  for (genvar z = 0; z < NUM_ZONES; z++) begin : g_one_chk
    single_zone_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (g_zone[z].ztype == ZONE_NOMON_ONE && g_zone[z].zobjs > 8'h1 && !muted && !ovr_act_q)
      |=> !status_hi) else $error("two objects accepted");
  end
endmodule // lcbm_top
